/* File: verification/can_io_pair_connection_properties.sv */
// Port-level checks of the pairing block
`timescale 1ns/1ps
`default_nettype none
module can_io_pair_connection_properties #(
  parameter [7:0] CNT_DO = 8'h08, CNT_DI = 8'h08, CNT_AO = 8'h00,
  parameter [7:0] CNT_AI = 8'h00, CNT_PWM = 8'h00, CNT_CNT = 8'h00
) (
  input wire        i_sys_clk,
  input wire        i_rst,
  input wire        i_clk_en,
  input wire [7:0]  i_node_id,
  input wire        i_tx_ready,
  input wire        o_tx_valid,
  input wire [28:0] o_tx_id,
  input wire [3:0]  o_tx_dlc,
  input wire [63:0] o_tx_data,
  input wire [7:0]  o_do,
  input wire        o_avs_waitrequest,
  input wire        o_pair_mode,
  input wire        o_baud_500k,
  input wire        o_operational,
  input wire        o_hb_lost
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  wire       ack = o_tx_id[24];
  wire [7:0] fc  = o_tx_id[23:16];
  a_tx_frame_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_id)
    && $stable(o_tx_data) && $stable(o_tx_dlc)) else $error("tx frame changed before accept");
  a_tx_reserved_zero: assert property (o_tx_valid |-> o_tx_id[28:25] == 4'h0) else $error("reserved bits set");
  a_iotype_length: assert property (o_tx_valid && fc == 8'hf3 |-> o_tx_dlc == 4'h6) else $error("io type dlc");
  a_iotype_counts: assert property (o_tx_valid && fc == 8'hf3 |-> o_tx_data[47:0] ==
    {CNT_CNT, CNT_PWM, CNT_AI, CNT_AO, CNT_DI, CNT_DO}) else $error("io type counts");
  a_pair_target: assert property (o_tx_valid && !ack && fc == 8'h10 |-> o_tx_id[15:8] == i_node_id + 8'h01
    && o_tx_dlc == 4'h8 && o_tx_id[7:0] == 8'h01) else $error("pair set frame");
  a_no_conflict_ans: assert property (o_pair_mode && o_tx_valid |-> !(ack && fc == 8'he0))
    else $error("id conflict answer in pair mode");
  a_no_hb_loss: assert property (o_pair_mode |-> !o_hb_lost) else $error("heartbeat lost in pair mode");
  a_pair_auto_oper: assert property (o_pair_mode |-> ##[0:4] o_operational) else $error("not operational");
  a_fast_needs_pair: assert property (o_baud_500k |-> ##[0:3] o_pair_mode) else $error("500k without pair");
  a_do_report: assert property (o_tx_valid && ack && fc == 8'h10 && o_tx_id[7:0] == 8'h01
    |-> o_tx_data[7:0] == o_do) else $error("do report value");
  a_one_wait_cycle: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("answer too long");
  a_freeze_hold: assert property (!i_clk_en |=> $stable(o_tx_valid) && $stable(o_do) && $stable(o_operational))
    else $error("state moved while clock enable low");
  c_iotype: cover property (o_tx_valid && i_tx_ready && fc == 8'hf3);
  c_pair_set: cover property (o_tx_valid && i_tx_ready && !ack);
  c_stall: cover property (o_tx_valid && !i_tx_ready);
endmodule // can_io_pair_connection_properties
`default_nettype wire

/* File: verification/can_io_pair_connection_test.sv */
// Bench for the pairing block with register and frame traffic
`timescale 1ns/1ps
`default_nettype none
module can_io_pair_connection_test;
  logic        i_sys_clk = 0, i_rst = 1, i_clk_en = 1, slow = 0;
  logic        i_avs_read = 0, i_avs_write = 0, i_rx_valid = 0, i_rx_rtr = 0;
  logic [3:0]  i_avs_address = 0, i_baud_switch = 4'hd, i_rx_dlc = 0;
  logic [31:0] i_avs_writedata = 0, q;
  logic [7:0]  i_node_id = 8'h09, i_di = 0;
  logic [28:0] i_rx_id = 0;
  logic [63:0] i_rx_data = 0;
  wire [31:0]  o_avs_readdata;
  wire         o_avs_waitrequest, o_tx_valid, i_tx_ready, o_tx_rtr;
  wire         o_pair_mode, o_baud_500k, o_operational, o_hb_lost;
  wire [7:0]   o_do;
  wire [28:0]  o_tx_id;
  wire [3:0]   o_tx_dlc;
  wire [63:0]  o_tx_data;
  int          err_count = 0, samples_checked = 0, seen = 0;
  always #12.5 i_sys_clk = !i_sys_clk;
  can_io_pair_connection #(.CNT_DO(8'h08), .CNT_DI(8'h04), .CNT_AO(8'h01), .CNT_AI(8'h02),
    .CNT_PWM(8'h03), .CNT_CNT(8'h05), .MS_CYCLES(4)) dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_clk_en(i_clk_en), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_baud_switch(i_baud_switch), .i_node_id(i_node_id), .i_di(i_di), .o_do(o_do), .i_rx_valid(i_rx_valid),
    .i_rx_id(i_rx_id), .i_rx_rtr(i_rx_rtr), .i_rx_dlc(i_rx_dlc), .i_rx_data(i_rx_data), .o_tx_valid(o_tx_valid),
    .i_tx_ready(i_tx_ready), .o_tx_id(o_tx_id), .o_tx_rtr(o_tx_rtr), .o_tx_dlc(o_tx_dlc), .o_tx_data(o_tx_data),
    .o_pair_mode(o_pair_mode), .o_baud_500k(o_baud_500k), .o_operational(o_operational), .o_hb_lost(o_hb_lost));
  can_peer_model peer_u (.i_sys_clk(i_sys_clk), .i_slow(slow), .i_valid(o_tx_valid), .i_id(o_tx_id),
    .i_dlc(o_tx_dlc), .i_data(o_tx_data), .o_ready(i_tx_ready));
  task complete_run;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge i_sys_clk);
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    k = 0;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (o_avs_waitrequest !== 1'b0 && k < 40);
    if (o_avs_waitrequest !== 1'b0) begin
      err_count++;
      complete_run;
    end
    q = o_avs_readdata;
    i_avs_read <= 0;
    i_avs_write <= 0;
  endtask
  task rx(input logic [7:0] fc, input logic [7:0] sel, input logic rtr, input logic [3:0] dlc, input logic [63:0] d);
    @(posedge i_sys_clk);
    i_rx_valid <= 1;
    i_rx_id <= {4'h0, 1'b0, fc, i_node_id, sel};
    i_rx_rtr <= rtr;
    i_rx_dlc <= dlc;
    i_rx_data <= d;
    @(posedge i_sys_clk);
    i_rx_valid <= 0;
  endtask
  task frame(input logic [28:0] id, input logic [3:0] dlc, input logic [63:0] d);
    int k;
    logic [63:0] m;
    for (k = 0; k < 200 && peer_u.count <= seen; k++) @(posedge i_sys_clk);
    if (k == 200) begin
      err_count++;
      complete_run;
    end
    m = (dlc == 4'h8) ? '1 : ((64'h1 << (dlc * 8)) - 64'h1);
    chk("tx id", id, peer_u.ids[seen]);
    chk("tx dlc", dlc, peer_u.dlcs[seen]);
    chk("tx rtr", 0, o_tx_rtr);
    chk("tx data", d & m, peer_u.datas[seen] & m);
    seen++;
  endtask
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 0;
    repeat (10) @(posedge i_sys_clk);
    chk("pair mode", 1, o_pair_mode);
    chk("baud 500k", 1, o_baud_500k);
    chk("operational", 1, o_operational);
    rx(8'hf3, 8'h00, 1, 4'h6, 0);
    frame({5'h01, 8'hf3, 8'h09, 8'h00}, 4'h6, 64'h0503_0201_0408);
    slow <= 1;
    i_di <= 8'h55;
    frame({5'h00, 8'h10, 8'h0a, 8'h01}, 4'h8, 64'h55);
    frame({5'h01, 8'h10, 8'h09, 8'h02}, 4'h1, 64'h55);
    rx(8'h10, 8'h01, 0, 4'h8, 64'haa);
    frame({5'h01, 8'h10, 8'h09, 8'h01}, 4'h1, 64'haa);
    chk("do pins", 8'haa, o_do);
    i_clk_en <= 0;
    i_di <= 8'h0f;
    repeat (20) @(posedge i_sys_clk);
    chk("frozen frames", seen, peer_u.count);
    chk("frozen valid", 0, o_tx_valid);
    i_clk_en <= 1;
    frame({5'h00, 8'h10, 8'h0a, 8'h01}, 4'h8, 64'h0f);
    frame({5'h01, 8'h10, 8'h09, 8'h02}, 4'h1, 64'h0f);
    bus(1, 4'h4, 32'h2);
    rx(8'he0, 8'h00, 0, 4'h1, 0);
    repeat (40) @(posedge i_sys_clk);
    chk("frame count", seen, peer_u.count);
    chk("hb lost", 0, o_hb_lost);
    bus(0, 4'h4, 0);
    chk("hb timeout", 32'h2, q);
    bus(0, 4'h1, 0);
    chk("status", 32'h00aa_0fd7, q);
    bus(0, 4'hf, 0);
    chk("unmapped", 0, q);
    i_rst <= 1;
    i_baud_switch <= 4'h7;
    // input node keeps an odd id
    i_node_id <= 8'h0b;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 0;
    repeat (10) @(posedge i_sys_clk);
    chk("pair mode", 0, o_pair_mode);
    chk("baud 500k", 0, o_baud_500k);
    rx(8'he0, 8'h00, 0, 4'h1, 0);
    frame({5'h01, 8'he0, 8'h0b, 8'h00}, 4'h1, 0);
    bus(1, 4'h0, 32'h1);
    @(posedge i_sys_clk);
    chk("operational", 1, o_operational);
    bus(1, 4'h4, 32'h2);
    repeat (20) @(posedge i_sys_clk);
    chk("hb lost", 1, o_hb_lost);
    rx(8'h70, 8'h00, 0, 4'h0, 0);
    @(posedge i_sys_clk);
    chk("hb cleared", 0, o_hb_lost);
    complete_run;
  end
endmodule // can_io_pair_connection_test
bind can_io_pair_connection can_io_pair_connection_properties #(.CNT_DO(CNT_DO), .CNT_DI(CNT_DI),
  .CNT_AO(CNT_AO), .CNT_AI(CNT_AI), .CNT_PWM(CNT_PWM), .CNT_CNT(CNT_CNT)) chk_u (.i_sys_clk(i_sys_clk),
  .i_rst(i_rst), .i_clk_en(i_clk_en), .i_node_id(i_node_id), .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid),
  .o_tx_id(o_tx_id), .o_tx_dlc(o_tx_dlc), .o_tx_data(o_tx_data), .o_do(o_do),
  .o_avs_waitrequest(o_avs_waitrequest), .o_pair_mode(o_pair_mode), .o_baud_500k(o_baud_500k),
  .o_operational(o_operational), .o_hb_lost(o_hb_lost));
`default_nettype wire

/* File: verification/can_peer_model.sv */
// Far-side CAN controller model that accepts and records frames
`timescale 1ns/1ps
`default_nettype none
module can_peer_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_slow,
  input  wire logic        i_valid,
  input  wire logic [28:0] i_id,
  input  wire logic [3:0]  i_dlc,
  input  wire logic [63:0] i_data,
  output logic             o_ready = 1'b0
);
  logic [28:0] ids[32];
  logic [3:0]  dlcs[32];
  logic [63:0] datas[32];
  int          count = 0;
  logic [1:0]  gap = 2'h0;
  always @(posedge i_sys_clk) begin
    gap <= gap + 2'h1;
    o_ready <= !i_slow || gap == 2'h3;
    if (i_valid && o_ready) begin
      ids[count] <= i_id;
      dlcs[count] <= i_dlc;
      datas[count] <= i_data;
      count <= count + 1;
    end
  end
endmodule // can_peer_model
`default_nettype wire

/* File: verilog/can_io_pair_connection.v */
// Command interpreter and I/O pair-connection logic of a CAN digital I/O slave
// What this block does
// - I/O-type answer carries six data bytes
// - Bytes: DO, DI, AO, AI, PWM, counter counts
// - Input ON drives paired same-numbered output ON
// - Pair mode only for switch 0x8 to 0xF
// - Setting D: 500 kbps, operational by itself
// - One-to-many and many-to-one pairing with shared IDs
// - No ID-conflict answer in pair mode
// - Heartbeat supervision off in pair mode
// - Master set and query still answered
// - Input change sends pair set, then report
// - Output node updates outputs then reports them
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "can_io_pair_regs.vh"

module can_io_pair_connection #(
  parameter [7:0] CNT_DO   = 8'h08,
  parameter [7:0] CNT_DI   = 8'h08,
  parameter [7:0] CNT_AO   = 8'h00,
  parameter [7:0] CNT_AI   = 8'h00,
  parameter [7:0] CNT_PWM  = 8'h00,
  parameter [7:0] CNT_CNT  = 8'h00,
  parameter       MS_CYCLES = `CYC_PER_MS
) (
  input  wire        i_sys_clk,
  input  wire        i_rst,
  input  wire        i_clk_en,
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  input  wire [3:0]  i_baud_switch,
  input  wire [7:0]  i_node_id,
  input  wire [7:0]  i_di,
  output reg  [7:0]  o_do,
  input  wire        i_rx_valid,
  input  wire [28:0] i_rx_id,
  input  wire        i_rx_rtr,
  input  wire [3:0]  i_rx_dlc,
  input  wire [63:0] i_rx_data,
  output reg         o_tx_valid,
  input  wire        i_tx_ready,
  output reg  [28:0] o_tx_id,
  output reg         o_tx_rtr,
  output reg  [3:0]  o_tx_dlc,
  output reg  [63:0] o_tx_data,
  output reg         o_pair_mode,
  output reg         o_baud_500k,
  output reg         o_operational,
  output reg         o_hb_lost
);

  function [28:0] mk_id;
    input       ack;
    input [7:0] func;
    input [7:0] node;
    input [7:0] sel;
    begin
      mk_id = {4'h0, ack, func, node, sel};
    end
  endfunction

  // Pin synchronisers
  reg  [7:0]  di_s1;
  reg  [7:0]  di_s2;
  reg  [7:0]  di_prev;
  reg  [3:0]  sw_s1;
  reg  [3:0]  sw_s2;
  reg  [7:0]  id_s1;
  reg  [7:0]  id_s2;
  reg  [1:0]  boot_cnt;
  reg  [7:0]  node_id;

  reg  [31:0] ctrl;
  reg  [47:0] counts;
  reg  [15:0] hb_timeout;
  reg  [15:0] hb_ms;
  reg  [31:0] ms_div;

  reg         p_iotype;
  reg         p_idc;
  reg         p_dostat;
  reg         p_pairset;
  reg         p_direport;

  wire [7:0]  rx_func = i_rx_id[`ID_FUNC_MSB:`ID_FUNC_LSB];
  wire [7:0]  rx_node = i_rx_id[`ID_NODE_MSB:`ID_NODE_LSB];
  wire [7:0]  rx_sel  = i_rx_id[`ID_SEL_MSB:`ID_SEL_LSB];
  wire        rx_cmd  = i_rx_valid && !i_rx_id[`ID_ACK_BIT];
  wire        rx_mine = rx_cmd && (rx_node == node_id);
  wire        booted  = (boot_cnt == 2'h3);
  // Input changes count only after the boot load
  wire        di_chg  = booted && (di_s2 != di_prev);
  // Next frame may load on the edge the last is taken
  wire        tx_free = !o_tx_valid || i_tx_ready;

  // Decoded commands
  // A set without a data byte is ignored
  wire set_do   = rx_mine && rx_func == `FC_DIO && rx_sel == `SEL_DO && !i_rx_rtr && i_rx_dlc != 4'h0;
  wire qry_do   = rx_mine && rx_func == `FC_DIO && rx_sel == `SEL_DO && i_rx_rtr;
  wire qry_di   = rx_mine && rx_func == `FC_DIO && rx_sel == `SEL_DI && i_rx_rtr;
  wire qry_type = rx_mine && rx_func == `FC_IO_TYPE && i_rx_rtr;
  wire qry_idc  = rx_mine && rx_func == `FC_ID_CHECK;
  wire hb_seen  = rx_cmd && rx_func == `FC_HEARTBEAT;

  // Transmit arbitration: I/O-type, ID-check and DO answers first, then pair set, then DI report or DI answer
  wire ld_iotype  = tx_free && p_iotype;
  wire ld_idc     = tx_free && !p_iotype && p_idc;
  wire ld_dostat  = tx_free && !p_iotype && !p_idc && p_dostat;
  wire ld_pairset = tx_free && !p_iotype && !p_idc && !p_dostat && p_pairset;
  wire ld_direp   = tx_free && !p_iotype && !p_idc && !p_dostat && !p_pairset
                    && p_direport;

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      di_s1 <= 8'h00;
      di_s2 <= 8'h00;
      di_prev <= 8'h00;
      sw_s1 <= 4'h0;
      sw_s2 <= 4'h0;
      id_s1 <= 8'h00;
      id_s2 <= 8'h00;
      boot_cnt <= 2'h0;
      node_id <= 8'h00;
      o_pair_mode <= 1'b0;
      o_baud_500k <= 1'b0;
    end else if (i_clk_en) begin
      di_s1 <= i_di;
      di_s2 <= di_s1;
      di_prev <= di_s2;
      sw_s1 <= i_baud_switch;
      sw_s2 <= sw_s1;
      id_s1 <= i_node_id;
      id_s2 <= id_s1;
      if (!booted) begin
        boot_cnt <= boot_cnt + 2'h1;
        node_id <= id_s2;
        o_pair_mode <= sw_s2[`SW_PAIR_BIT];
        o_baud_500k <= (sw_s2 == `SW_500K_PAIR);
      end
    end
  end

  // Pending transmit requests; a new set beats the load clear
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      p_iotype <= 1'b0;
      p_idc <= 1'b0;
      p_dostat <= 1'b0;
      p_pairset <= 1'b0;
      p_direport <= 1'b0;
    end else if (i_clk_en) begin
      p_iotype <= qry_type || (p_iotype && !ld_iotype);
      // conflict answer suppressed in pair mode
      p_idc <= (qry_idc && !o_pair_mode) || (p_idc && !ld_idc);
      p_dostat <= set_do || qry_do || (p_dostat && !ld_dostat);
      // input change queues set then report
      p_pairset <= (di_chg && o_pair_mode && o_operational)
                   || (p_pairset && !ld_pairset);
      p_direport <= qry_di || (di_chg && o_pair_mode && o_operational)
                    || (p_direport && !ld_direp);
    end
  end

  // Frame builder
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_valid <= 1'b0;
      o_tx_id <= 29'h0000_0000;
      o_tx_rtr <= 1'b0;
      o_tx_dlc <= 4'h0;
      o_tx_data <= 64'h0000_0000_0000_0000;
    end else if (i_clk_en && tx_free) begin
      o_tx_valid <= p_iotype || p_idc || p_dostat || p_pairset || p_direport;
      o_tx_rtr <= 1'b0;
      if (ld_iotype) begin
        o_tx_id <= mk_id(1'b1, `FC_IO_TYPE, node_id, `SEL_NONE);
        o_tx_dlc <= `DLC_IO_TYPE;
        // byte 0 first, DO to counter
        o_tx_data <= {16'h0000, counts[47:40], counts[39:32], counts[31:24],
                      counts[23:16], counts[15:8], counts[7:0]};
      end else if (ld_idc) begin
        o_tx_id <= mk_id(1'b1, `FC_ID_CHECK, node_id, `SEL_NONE);
        o_tx_dlc <= `DLC_ONE;
        o_tx_data <= 64'h0000_0000_0000_0000;
      end else if (ld_dostat) begin
        o_tx_id <= mk_id(1'b1, `FC_DIO, node_id, `SEL_DO);
        o_tx_dlc <= `DLC_ONE;
        o_tx_data <= {56'h0, o_do};
      end else if (ld_pairset) begin
        // partner is own ID plus one
        o_tx_id <= mk_id(1'b0, `FC_DIO, node_id + 8'h01, `SEL_DO);
        o_tx_dlc <= `DLC_PAIR_SET;
        o_tx_data <= {56'h0, di_prev};
      end else if (ld_direp) begin
        o_tx_id <= mk_id(1'b1, `FC_DIO, node_id, `SEL_DI);
        o_tx_dlc <= `DLC_ONE;
        o_tx_data <= {56'h0, di_prev};
      end
    end
  end

  // Outputs and operational state
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_do <= 8'h00;
      o_operational <= 1'b0;
    end else if (i_clk_en) begin
      // only a DO set addressed to this node's ID drives these outputs
      if (set_do) begin
        o_do <= i_rx_data[7:0];
      end
      if (booted && (o_pair_mode || ctrl[`CTRL_GO_OP_BIT])) begin
        o_operational <= 1'b1;
      end
    end
  end

  // Host heartbeat supervision
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ms_div <= 32'h0000_0000;
      hb_ms <= 16'h0000;
      o_hb_lost <= 1'b0;
    end else if (i_clk_en) begin
      // supervision held off in pair mode
      if (o_pair_mode || hb_timeout == 16'h0000 || hb_seen) begin
        ms_div <= 32'h0000_0000;
        hb_ms <= 16'h0000;
        o_hb_lost <= 1'b0;
      end else if (ms_div == MS_CYCLES - 1) begin
        ms_div <= 32'h0000_0000;
        // Lost when whole milliseconds reach the limit
        if (hb_ms + 16'h0001 >= hb_timeout) begin
          o_hb_lost <= 1'b1;
        end else begin
          hb_ms <= hb_ms + 16'h0001;
        end
      end else begin
        ms_div <= ms_div + 32'h0000_0001;
      end
    end
  end

  // Avalon-MM slave, one wait cycle per access
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
      ctrl <= `CTRL_RESET_VAL;
      counts <= 48'h0000_0000_0000;
      hb_timeout <= `HB_TIMEOUT_RST;
    end else if (!booted && i_clk_en) begin
      // Bus held off until pins and counts settle
      counts <= {CNT_CNT, CNT_PWM, CNT_AI, CNT_AO, CNT_DI, CNT_DO};
    end else if (i_clk_en) begin
      // Wait back up after each one-cycle answer
      if (!o_avs_waitrequest) begin
        o_avs_waitrequest <= 1'b1;
      end else if (i_avs_read || i_avs_write) begin
        o_avs_waitrequest <= 1'b0;
        o_avs_readdata <= 32'h0000_0000;
        if (i_avs_write) begin
          case (i_avs_address)
            `REG_CTRL:       ctrl <= i_avs_writedata;
            `REG_COUNTS_LO:  counts[31:0] <= i_avs_writedata;
            `REG_COUNTS_HI:  counts[47:32] <= i_avs_writedata[15:0];
            `REG_HB_TIMEOUT: hb_timeout <= i_avs_writedata[15:0];
            default:         ;
          endcase
        end else begin
          case (i_avs_address)
            `REG_CTRL:       o_avs_readdata <= ctrl;
            // Mode flags, switch, inputs, outputs
            `REG_STATUS:     o_avs_readdata <= {8'h00, o_do, di_prev,
                                                sw_s2, o_hb_lost, o_baud_500k,
                                                o_operational, o_pair_mode};
            `REG_COUNTS_LO:  o_avs_readdata <= counts[31:0];
            `REG_COUNTS_HI:  o_avs_readdata <= {16'h0000, counts[47:32]};
            `REG_HB_TIMEOUT: o_avs_readdata <= {16'h0000, hb_timeout};
            default:         o_avs_readdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

endmodule // can_io_pair_connection
`default_nettype wire

/* File: verilog/can_io_pair_regs.vh */
// Register offsets, frame layout, codes and timing for the pairing block
`ifndef CAN_IO_PAIR_REGS_VH
`define CAN_IO_PAIR_REGS_VH

// Avalon word addresses (byte offset / 4)
`define REG_CTRL        4'h0
`define REG_STATUS      4'h1
`define REG_COUNTS_LO   4'h2
`define REG_COUNTS_HI   4'h3
`define REG_HB_TIMEOUT  4'h4

// Control register fields
`define CTRL_GO_OP_BIT   0
`define CTRL_RESET_VAL   32'h0000_0000
`define HB_TIMEOUT_RST   16'h0000

// Extended identifier fields
`define ID_ACK_BIT      24
`define ID_FUNC_MSB     23
`define ID_FUNC_LSB     16
`define ID_NODE_MSB     15
`define ID_NODE_LSB     8
`define ID_SEL_MSB      7
`define ID_SEL_LSB      0

// Function codes and selectors
`define FC_DIO          8'h10
`define FC_ID_CHECK     8'he0
`define FC_HEARTBEAT    8'h70
`define FC_IO_TYPE      8'hf3
`define SEL_NONE        8'h00
`define SEL_DO          8'h01
`define SEL_DI          8'h02

// Baud switch
`define SW_PAIR_BIT     3
`define SW_500K_PAIR    4'hd

// Frame lengths
`define DLC_IO_TYPE     4'h6
`define DLC_PAIR_SET    4'h8
`define DLC_ONE         4'h1

// Timing: heartbeat timeout counted in milliseconds
`define CLK_HZ          40000000
`define TICK_MS         1
`define CYC_PER_MS      ((`CLK_HZ / 1000) * `TICK_MS)

`endif
